// *** design/trsc_top.sv ***
// Timer run, channel sync and general register pin-function control
// Functional notes
// (R1) Run bit per channel starts/stops its counter
// (R2) Sync register selects synchronised channels 0-4
// (R3) Reset and standby clear sync selects
// (R4) B-field 000 is compare, pin undriven
// (R5) B-field 001/010/011 clear/set/toggle pin
// (R6) B-field 100/101 capture on rise/fall
// (R7) B-field 110 captures on both edges
// (R8) Compare pin holds low until first match
// (R9) Channel 2 B-field toggle drives high instead; its A-field still toggles
// (R10) Control bit 7 ignores writes, reads undefined
// (R11) Control bit 3 reads one; write one
// (R12) A-field uses same encodings as B
// (R13) Synced channels write/clear/start together
`timescale 1ns/1ps
module trsc_top (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_n_i,
    input  wire logic                          standby_i,
    // Register port
    input  wire trsc_pkg::trsc_bus_s           bus_i,
    output logic [7:0]                         rdata_o,
    // Counter side
    output logic [trsc_pkg::NCH-1:0]           run_o,
    input  wire logic [trsc_pkg::NSYNC-1:0]    cnt_wr_req_i,
    input  wire logic [trsc_pkg::NSYNC-1:0]    cnt_clr_req_i,
    output logic [trsc_pkg::NSYNC-1:0]         cnt_wr_o,
    output logic [trsc_pkg::NSYNC-1:0]         cnt_clr_o,
    // Compare and capture, index 2*ch is A, 2*ch+1 is B
    input  wire logic [trsc_pkg::NGR-1:0]      match_i,
    output logic [trsc_pkg::NGR-1:0]           cap_o,
    // Timer pins
    input  wire logic [trsc_pkg::NGR-1:0]      pin_i,
    output trsc_pkg::trsc_pin_s [trsc_pkg::NGR-1:0] pin_o
);

    // Registers
    logic [trsc_pkg::NCH-1:0]   run_r;
    logic [trsc_pkg::NCH-1:0]   run_nxt;
    logic [trsc_pkg::NSYNC-1:0] sync_r;
    logic [trsc_pkg::NSYNC-1:0] sync_nxt;
    logic [2:0]                 fn_a_r [trsc_pkg::NCH];
    logic [2:0]                 fn_b_r [trsc_pkg::NCH];
    logic [7:0]                 rdata_r;
    logic [7:0]                 rdata_nxt;
    logic [trsc_pkg::NSYNC-1:0] cnt_wr_r;
    logic [trsc_pkg::NSYNC-1:0] cnt_clr_r;

    // Address decode
    wire logic                 wr_run_w  = bus_i.wr && bus_i.addr == trsc_pkg::OFS_RUN;
    wire logic                 wr_sync_w = bus_i.wr && bus_i.addr == trsc_pkg::OFS_SYNC;
    wire logic                 rd_run_w  = bus_i.addr == trsc_pkg::OFS_RUN;
    wire logic                 rd_sync_w = bus_i.addr == trsc_pkg::OFS_SYNC;
    logic [trsc_pkg::NCH-1:0]  ioc_hit_w;

    function automatic logic [7:0] ioc_addr(input int ch);
        return trsc_pkg::OFS_IOC0 + 8'(ch) * trsc_pkg::OFS_STEP;
    endfunction

    // Spread a request over the whole sync group when any member raises it
    function automatic logic [trsc_pkg::NSYNC-1:0] group_spread(
        input logic [trsc_pkg::NSYNC-1:0] req,
        input logic [trsc_pkg::NSYNC-1:0] sel
    );
        return req | (sel & {trsc_pkg::NSYNC{|(req & sel)}});
    endfunction

    genvar g;
    generate
        for (g = 0; g < trsc_pkg::NCH; g++) begin : g_dec
            assign ioc_hit_w[g] = bus_i.addr == ioc_addr(g);
        end
    endgenerate

    // Run bits: a start on one synced channel starts the whole group
    wire logic [trsc_pkg::NSYNC-1:0] run_wr_w =
        {1'b0, bus_i.wdata[trsc_pkg::NCH-1:0]};
    wire logic [trsc_pkg::NSYNC-1:0] run_spread_w =
        group_spread(run_wr_w, sync_r); // R13

    assign run_nxt  = wr_run_w ? run_spread_w[trsc_pkg::NCH-1:0] : run_r; // R1
    assign sync_nxt = wr_sync_w ? bus_i.wdata[trsc_pkg::NSYNC-1:0] : sync_r; // R2

    // Read mux; unmapped addresses read zero
    logic [7:0] ioc_rd_w;

    always_comb begin
        ioc_rd_w = 8'h00;
        for (int c = 0; c < trsc_pkg::NCH; c++) begin
            if (ioc_hit_w[c]) begin
                ioc_rd_w = {trsc_pkg::IOC_B7_RD, fn_b_r[c],
                            trsc_pkg::IOC_B3_RD, fn_a_r[c]}; // R10 R11
            end
        end
    end

    always_comb begin
        rdata_nxt = 8'h00;
        if (bus_i.rd) begin
            if (rd_run_w) begin
                rdata_nxt = {4'h0, run_r};
            end else if (rd_sync_w) begin
                rdata_nxt = {trsc_pkg::SYNC_FIXED, sync_r}; // R3
            end else begin
                rdata_nxt = ioc_rd_w;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_r <= trsc_pkg::RUN_RST; // R1
        end else begin
            run_r <= run_nxt;
        end
    end

    // Standby clears the selects just as reset does
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_r <= trsc_pkg::SYNC_RST; // R3
        end else if (standby_i) begin
            sync_r <= trsc_pkg::SYNC_RST; // R3
        end else begin
            sync_r <= sync_nxt;
        end
    end

    // Bits 7 and 3 are not stored, so writes to them vanish
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int c = 0; c < trsc_pkg::NCH; c++) begin
                fn_a_r[c] <= trsc_pkg::FN_RST; // R12
                fn_b_r[c] <= trsc_pkg::FN_RST; // R4
            end
        end else begin
            for (int c = 0; c < trsc_pkg::NCH; c++) begin
                if (bus_i.wr && ioc_hit_w[c]) begin
                    fn_a_r[c] <= bus_i.wdata[trsc_pkg::IOC_A_LSB +: 3]; // R12
                    fn_b_r[c] <= bus_i.wdata[trsc_pkg::IOC_B_LSB +: 3]; // R4
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r   <= 8'h00;
            cnt_wr_r  <= '0;
            cnt_clr_r <= '0;
        end else begin
            rdata_r   <= rdata_nxt;
            cnt_wr_r  <= group_spread(cnt_wr_req_i, sync_r); // R13
            cnt_clr_r <= group_spread(cnt_clr_req_i, sync_r); // R13
        end
    end

    // One compare/capture unit per general register
    generate
        for (g = 0; g < trsc_pkg::NCH; g++) begin : g_ch
            trsc_gr_io #(
                .NO_TOGGLE (1'b0)
            ) u_gr_a (
                .clk_i   (clk_i),
                .rst_n_i (rst_n_i),
                .fn_i    (fn_a_r[g]),
                .match_i (match_i[2*g]),
                .pin_i   (pin_i[2*g]),
                .pin_o   (pin_o[2*g]),
                .cap_o   (cap_o[2*g])
            );
            trsc_gr_io #(
                .NO_TOGGLE (g == 2) // R9
            ) u_gr_b (
                .clk_i   (clk_i),
                .rst_n_i (rst_n_i),
                .fn_i    (fn_b_r[g]),
                .match_i (match_i[2*g+1]),
                .pin_i   (pin_i[2*g+1]),
                .pin_o   (pin_o[2*g+1]),
                .cap_o   (cap_o[2*g+1])
            );
        end
    endgenerate

    assign run_o     = run_r;
    assign rdata_o   = rdata_r;
    assign cnt_wr_o  = cnt_wr_r;
    assign cnt_clr_o = cnt_clr_r;

    // Checks

    AST_RUN_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R1
        wr_run_w && sync_r == '0 |=> run_o == $past(bus_i.wdata[3:0]))
        else $error("run bits do not follow the write");

    AST_RUN_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R1
        !wr_run_w |=> $stable(run_o))
        else $error("run bits changed without a write");

    AST_SYNC_READ: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2
        wr_sync_w && !standby_i ##1 (bus_i.rd && rd_sync_w && !standby_i)
        |=> rdata_o[4:0] == $past(bus_i.wdata[4:0], 2))
        else $error("sync select read-back mismatch");

    AST_SYNC_STANDBY: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
        standby_i ##1 (bus_i.rd && rd_sync_w)
        |=> rdata_o == {trsc_pkg::SYNC_FIXED, trsc_pkg::SYNC_RST})
        else $error("standby did not clear sync selects");

    AST_IOC_FIXED: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
        bus_i.rd && (|ioc_hit_w) |=> rdata_o[trsc_pkg::IOC_B3]
        && rdata_o[trsc_pkg::IOC_B7] == trsc_pkg::IOC_B7_RD)
        else $error("reserved control bits read wrong");

    AST_IOC_A_FIELD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
        bus_i.wr && ioc_hit_w[0] ##1 (bus_i.rd && ioc_hit_w[0] && !bus_i.wr)
        |=> rdata_o[2:0] == $past(bus_i.wdata[2:0], 2))
        else $error("A function field read-back mismatch");

    AST_SYNC_CLR: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
        (cnt_clr_req_i & sync_r) != '0 |=> (cnt_clr_o & $past(sync_r)) == $past(sync_r))
        else $error("clear not spread to all synced channels");

    AST_RD_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !bus_i.rd |=> rdata_o == 8'h00)
        else $error("read data present outside the answer cycle");

endmodule

// *** common/trsc_pkg.sv ***
// Shared constants and types for the timer run, sync and pin-function control block
package trsc_pkg;

    // Channel counts
    localparam int NCH   = 4;
    localparam int NSYNC = 5;
    localparam int NGR   = 2 * NCH;

    // Register byte addresses
    localparam logic [7:0] OFS_RUN  = 8'h00;
    localparam logic [7:0] OFS_SYNC = 8'h04;
    localparam logic [7:0] OFS_IOC0 = 8'h08;
    localparam logic [7:0] OFS_STEP = 8'h04;

    // Reset values
    localparam logic [3:0] RUN_RST  = 4'h0;
    localparam logic [4:0] SYNC_RST = 5'h00;
    localparam logic [2:0] FN_RST   = 3'h0;

    // Fixed read-back bits; the undefined top bits are shown as 1
    localparam logic [2:0] SYNC_FIXED = 3'h7;
    localparam logic       IOC_B7_RD  = 1'b1;
    localparam logic       IOC_B3_RD  = 1'b1;

    // Field positions in the pin-function register, plus the sync register top bit
    localparam int IOC_A_LSB = 0;
    localparam int IOC_B3    = 3;
    localparam int IOC_B_LSB = 4;
    localparam int IOC_B7    = 7;
    localparam int SYNC_MSB  = 7;

    // General register roles
    typedef enum logic [2:0] {
        TRSC_FN_OFF      = 3'h0,
        TRSC_FN_CLR      = 3'h1,
        TRSC_FN_SET      = 3'h2,
        TRSC_FN_TOG      = 3'h3,
        TRSC_FN_CAP_RISE = 3'h4,
        TRSC_FN_CAP_FALL = 3'h5,
        TRSC_FN_CAP_BOTH = 3'h6,
        TRSC_FN_RSV      = 3'h7
    } trsc_fn_e;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } trsc_bus_s;

    // Timer pin drive
    typedef struct packed {
        logic out;
        logic oe;
    } trsc_pin_s;

endpackage

// *** design/trsc_gr_io.sv ***
// Compare-output and input-capture logic for one general register and its pin
`timescale 1ns/1ps
module trsc_gr_io #(
    parameter logic NO_TOGGLE = 1'b0
) (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    // Configuration
    input  wire logic [2:0]         fn_i,
    // Timer events
    input  wire logic               match_i,
    input  wire logic               pin_i,
    // Results
    output trsc_pkg::trsc_pin_s     pin_o,
    output logic                    cap_o
);

    function automatic logic is_out_fn(input logic [2:0] f);
        return (f == trsc_pkg::TRSC_FN_CLR) || (f == trsc_pkg::TRSC_FN_SET)
            || (f == trsc_pkg::TRSC_FN_TOG);
    endfunction

    logic level_r;
    logic level_nxt;
    logic oe_r;
    logic prev_r;
    logic cap_r;
    logic cap_nxt;

    wire logic rise_w = pin_i & ~prev_r;
    wire logic fall_w = ~pin_i & prev_r;

    always_comb begin
        level_nxt = level_r;
        if (match_i && is_out_fn(fn_i)) begin
            case (fn_i)
                trsc_pkg::TRSC_FN_CLR: level_nxt = 1'b0; // R5
                trsc_pkg::TRSC_FN_SET: level_nxt = 1'b1; // R5
                // With NO_TOGGLE set (channel 2 B register) toggle drives high instead
                trsc_pkg::TRSC_FN_TOG: level_nxt = NO_TOGGLE ? 1'b1 : ~level_r; // R5 R9
                default:               level_nxt = level_r;
            endcase
        end
    end

    always_comb begin
        case (fn_i)
            trsc_pkg::TRSC_FN_CAP_RISE: cap_nxt = rise_w; // R6
            trsc_pkg::TRSC_FN_CAP_FALL: cap_nxt = fall_w; // R6
            trsc_pkg::TRSC_FN_CAP_BOTH: cap_nxt = rise_w | fall_w; // R7
            default:                    cap_nxt = 1'b0;
        endcase
    end

    // Level starts low and only a match moves it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_r <= 1'b0; // R8
            oe_r    <= 1'b0;
            prev_r  <= 1'b0;
            cap_r   <= 1'b0;
        end else begin
            level_r <= level_nxt;
            oe_r    <= is_out_fn(fn_i); // R4
            prev_r  <= pin_i;
            cap_r   <= cap_nxt;
        end
    end

    assign pin_o.out = level_r;
    assign pin_o.oe  = oe_r;
    assign cap_o     = cap_r;

    AST_OFF_NO_DRIVE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R4
        fn_i == trsc_pkg::TRSC_FN_OFF |=> !pin_o.oe)
        else $error("pin driven while compare output disabled");

    AST_CLR_LOW: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
        match_i && fn_i == trsc_pkg::TRSC_FN_CLR |=> pin_o.oe && !pin_o.out)
        else $error("clear-on-match did not drive low");

    AST_SET_HIGH: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R9
        match_i && (fn_i == trsc_pkg::TRSC_FN_SET
        || (NO_TOGGLE && fn_i == trsc_pkg::TRSC_FN_TOG)) |=> pin_o.out)
        else $error("set-on-match did not drive high");

    AST_TOGGLE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
        match_i && !NO_TOGGLE && fn_i == trsc_pkg::TRSC_FN_TOG
        |=> pin_o.out != $past(pin_o.out))
        else $error("toggle-on-match did not invert");

    AST_HOLD_NO_MATCH: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R8
        !match_i |=> $stable(pin_o.out))
        else $error("pin level moved without a match");

    AST_CAP_RISE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R6
        fn_i == trsc_pkg::TRSC_FN_CAP_RISE ##1
        ($rose(pin_i) && $stable(fn_i)) |=> cap_o)
        else $error("rising edge not captured");

    AST_CAP_BOTH: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R7
        fn_i == trsc_pkg::TRSC_FN_CAP_BOTH ##1
        (!$stable(pin_i) && $stable(fn_i)) |=> cap_o)
        else $error("edge not captured in both-edge mode");

endmodule

// *** testbench/trsc_top_bench.sv ***
// Self-checking bench for the timer run, sync and pin-function control block
`timescale 1ns/1ps
module trsc_top_bench;

    logic                                   clk_i;
    logic                                   rst_n_i;
    logic                                   standby_i;
    trsc_pkg::trsc_bus_s                    bus_i;
    logic [7:0]                             rdata_o;
    logic [trsc_pkg::NCH-1:0]               run_o;
    logic [trsc_pkg::NSYNC-1:0]             cnt_wr_req_i;
    logic [trsc_pkg::NSYNC-1:0]             cnt_clr_req_i;
    logic [trsc_pkg::NSYNC-1:0]             cnt_wr_o;
    logic [trsc_pkg::NSYNC-1:0]             cnt_clr_o;
    logic [trsc_pkg::NGR-1:0]               match_i;
    logic [trsc_pkg::NGR-1:0]               cap_o;
    logic [trsc_pkg::NGR-1:0]               pin_i;
    trsc_pkg::trsc_pin_s [trsc_pkg::NGR-1:0] pin_o;
    int                                     num_errors;
    int                                     checks_done;

    trsc_top i_dut (
        .clk_i         (clk_i),
        .rst_n_i       (rst_n_i),
        .standby_i     (standby_i),
        .bus_i         (bus_i),
        .rdata_o       (rdata_o),
        .run_o         (run_o),
        .cnt_wr_req_i  (cnt_wr_req_i),
        .cnt_clr_req_i (cnt_clr_req_i),
        .cnt_wr_o      (cnt_wr_o),
        .cnt_clr_o     (cnt_clr_o),
        .match_i       (match_i),
        .cap_o         (cap_o),
        .pin_i         (pin_i),
        .pin_o         (pin_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_i.addr  <= a;
        bus_i.wdata <= d;
        bus_i.wr    <= 1'b1;
        @(posedge clk_i);
        bus_i.wr    <= 1'b0;
        #1;
    endtask

    // Write then read the same address with no idle cycle between
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_i);
        bus_i.addr  <= a;
        bus_i.wdata <= d;
        bus_i.wr    <= 1'b1;
        @(posedge clk_i);
        bus_i.wr    <= 1'b0;
        bus_i.rd    <= 1'b1;
        @(posedge clk_i);
        bus_i.rd    <= 1'b0;
        #1;
        q = rdata_o;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        bus_i.addr <= a;
        bus_i.rd   <= 1'b1;
        @(posedge clk_i);
        bus_i.rd   <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    function automatic logic [7:0] ioc(input int ch);
        return 8'(trsc_pkg::OFS_IOC0 + trsc_pkg::OFS_STEP * ch);
    endfunction

    // Returns {oe, out} of one pin after a single match pulse
    task automatic hit(input int idx, output logic [7:0] v);
        @(posedge clk_i);
        match_i <= 8'(1 << idx);
        @(posedge clk_i);
        match_i <= 8'h00;
        #1;
        v = 8'({pin_o[idx].oe, pin_o[idx].out});
    endtask

    // Counts capture pulses in a short window after a pin edge
    task automatic edge_cnt(input int idx, input logic lvl, output logic [7:0] n);
        n = 8'h00;
        @(posedge clk_i);
        pin_i[idx] <= lvl;
        repeat (4) begin
            @(posedge clk_i);
            #1;
            if (cap_o[idx] === 1'b1) n = n + 8'h01;
        end
    endtask

    task automatic t_regs();
        logic [7:0] v;
        rd(trsc_pkg::OFS_RUN, v);  chk(v, 8'h00);
        rd(trsc_pkg::OFS_SYNC, v); chk(v, 8'he0);
        rd(ioc(0), v);             chk(v, 8'h88);
        rd(ioc(3), v);             chk(v, 8'h88);
        chk(8'({pin_o[1].oe, pin_o[1].out}), 8'h00);
        // Bit 7 written low must still read high
        wr(ioc(1), 8'h08);
        rd(ioc(1), v);             chk(v, 8'h88);
        wr(ioc(1), 8'hf8);
        rd(ioc(1), v);             chk(v, 8'hf8);
        wr(ioc(1), 8'h08);
        wr(8'hf0, 8'hff);
        rd(8'hf0, v);              chk(v, 8'h00);
        rd(trsc_pkg::OFS_RUN, v);  chk(v, 8'h00);
        wr_rd(ioc(0), 8'h0d, v);   chk(v, 8'h8d);
        $display("test regs done");
    endtask

    task automatic t_run();
        logic [7:0] v;
        wr(trsc_pkg::OFS_RUN, 8'h0a);
        chk(8'(run_o), 8'h0a);
        rd(trsc_pkg::OFS_RUN, v);  chk(v, 8'h0a);
        wr(trsc_pkg::OFS_RUN, 8'h05);
        chk(8'(run_o), 8'h05);
        wr(trsc_pkg::OFS_RUN, 8'h00);
        chk(8'(run_o), 8'h00);
        $display("test run done");
    endtask

    task automatic t_sync();
        logic [7:0] v;
        wr_rd(trsc_pkg::OFS_SYNC, 8'h13, v); chk(v, 8'hf3);
        @(posedge clk_i);
        cnt_clr_req_i <= 5'h01;
        @(posedge clk_i);
        cnt_clr_req_i <= 5'h00;
        cnt_wr_req_i  <= 5'h10;
        #1;
        chk(8'(cnt_clr_o), 8'h13);
        @(posedge clk_i);
        cnt_wr_req_i  <= 5'h04;
        #1;
        chk(8'(cnt_wr_o), 8'h13);
        @(posedge clk_i);
        cnt_wr_req_i  <= 5'h00;
        #1;
        chk(8'(cnt_wr_o), 8'h04);
        // A start on one synced channel starts the whole group
        wr(trsc_pkg::OFS_RUN, 8'h01);
        chk(8'(run_o), 8'h03);
        wr(trsc_pkg::OFS_RUN, 8'h00);
        // Standby stays high across the read and blocks a later write
        @(posedge clk_i);
        standby_i <= 1'b1;
        rd(trsc_pkg::OFS_SYNC, v); chk(v, 8'he0);
        wr(trsc_pkg::OFS_SYNC, 8'h1f);
        rd(trsc_pkg::OFS_SYNC, v); chk(v, 8'he0);
        @(posedge clk_i);
        standby_i <= 1'b0;
        $display("test sync done");
    endtask

    task automatic t_compare();
        logic [7:0] v;
        wr(ioc(0), 8'h18);
        repeat (2) @(posedge clk_i);
        #1;
        chk(8'(pin_o[1].out), 8'h00);
        hit(1, v); chk(v, 8'h02);
        wr(ioc(0), 8'h28);
        hit(1, v); chk(v, 8'h03);
        wr(ioc(0), 8'h38);
        hit(1, v); chk(v, 8'h02);
        hit(1, v); chk(v, 8'h03);
        wr(ioc(0), 8'h08);
        repeat (2) @(posedge clk_i);
        hit(1, v); chk(8'(v[1]), 8'h00);
        wr(ioc(2), 8'h38);
        hit(5, v); chk(v, 8'h03);
        hit(5, v); chk(v, 8'h03);
        wr(ioc(1), 8'h0a);
        hit(2, v); chk(v, 8'h03);
        wr(ioc(1), 8'h0b);
        hit(2, v); chk(v, 8'h02);
        $display("test compare done");
    endtask

    task automatic t_capture();
        logic [7:0] n;
        wr(ioc(0), 8'h48);
        edge_cnt(1, 1'b1, n); chk(n, 8'h01);
        edge_cnt(1, 1'b0, n); chk(n, 8'h00);
        wr(ioc(0), 8'h58);
        edge_cnt(1, 1'b1, n); chk(n, 8'h00);
        edge_cnt(1, 1'b0, n); chk(n, 8'h01);
        wr(ioc(0), 8'h68);
        edge_cnt(1, 1'b1, n); chk(n, 8'h01);
        edge_cnt(1, 1'b0, n); chk(n, 8'h01);
        wr(ioc(3), 8'h0c);
        edge_cnt(6, 1'b1, n); chk(n, 8'h01);
        $display("test capture done");
    endtask

    initial begin
        #(25 * 6000);
        num_errors++;
        final_report();
    end

    initial begin
        num_errors    = 0;
        checks_done   = 0;
        rst_n_i       = 1'b0;
        standby_i     = 1'b0;
        bus_i         = '0;
        cnt_wr_req_i  = '0;
        cnt_clr_req_i = '0;
        match_i       = '0;
        pin_i         = '0;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_run();
        t_sync();
        t_compare();
        t_capture();
        final_report();
    end

endmodule
